// ### verilog/art_timer.sv
/*
 Auto-reload timer: 16-bit or split 8-bit, with low-frequency oscillator capture.
 Assumes a register master with one-cycle strobes and read data a cycle later;
 the oscillator inputs are asynchronous and synchronised inside.
*/
// Local design decisions: the register addresses and the address-and-strobe port.
`timescale 1ns/1ns
module art_timer (
	input  wire logic       clk_i,      // System clock, 100 MHz
	input  wire logic       rst_n_i,    // Asynchronous reset, active low
	input  wire logic       ce_i,       // Clock enable, freezes all state
	input  wire logic [2:0] addr_i,     // Register address
	input  wire logic [7:0] wdata_i,    // Write data
	input  wire logic       wr_i,       // Write strobe
	input  wire logic       rd_i,       // Read strobe
	input  wire logic       ext_osc_i,  // External oscillator
	input  wire logic       lfo_i,      // Low-frequency oscillator
	output logic      [7:0] rdata_o,    // Read data, cycle after strobe
	output logic            irq_o       // Interrupt request, one cycle
);
	// ****************************************
	// Reset release
	// ****************************************
	logic [1:0] rst_sync_reg;
	logic       rst_n;

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rst_sync_reg <= 2'h0;
		end else begin
			rst_sync_reg <= {rst_sync_reg[0], 1'b1};
		end
	end

	// Release is synchronous so every flop leaves reset on the same edge
	assign rst_n = rst_sync_reg[1];

	// ****************************************
	// State
	// ****************************************
	// Every register and both outputs live in this one state word
	typedef struct packed {
		logic [7:0] timer_control_reg;
		logic [7:0] reload_low_byte;
		logic [7:0] reload_high_byte;
		logic [7:0] count_low_byte;
		logic [7:0] count_high_byte;
		logic [7:0] clock_control_reg;
		logic [7:0] interrupt_enable_reg;
		logic [7:0] rdata;
		logic       irq;
	} art_state_type;

	art_state_type st_reg;
	art_state_type st_next;

	logic sys12_tick;
	logic ext8_tick;
	logic lfo_fall;

	art_prescaler u_pre (
		.clk_i     (clk_i),
		.rst_n_i   (rst_n),
		.ce_i      (ce_i),
		.ext_osc_i (ext_osc_i),
		.sys12_o   (sys12_tick),
		.ext8_o    (ext8_tick)
	);

	art_sync u_lfo_sync (
		.clk_i   (clk_i),
		.rst_n_i (rst_n),
		.ce_i    (ce_i),
		.async_i (lfo_i),
		.level_o (),
		.fall_o  (lfo_fall)
	);

	// ****************************************
	// Mode decode
	// ****************************************
	logic       split;
	logic       capture;
	logic       run;
	logic       ext_sel;
	logic       low_sys_sel;
	logic       high_sys_sel;
	logic       timer_irq_en;
	logic       low_irq_en;
	logic       capture_event;
	logic [7:0] rd_val;

	assign split        = st_reg.timer_control_reg[art_pkg::BIT_SPLIT];
	assign capture      = st_reg.timer_control_reg[art_pkg::BIT_CAPTURE_EN]
		& st_reg.timer_control_reg[art_pkg::BIT_CAPTURE_SRC];
	assign run          = st_reg.timer_control_reg[art_pkg::BIT_RUN];
	assign ext_sel      = st_reg.timer_control_reg[art_pkg::BIT_EXT_CLK];
	assign low_sys_sel  = st_reg.clock_control_reg[art_pkg::BIT_LOW_CLK_SEL];
	assign high_sys_sel = st_reg.clock_control_reg[art_pkg::BIT_HIGH_CLK_SEL];
	assign timer_irq_en = st_reg.interrupt_enable_reg[art_pkg::BIT_TIMER_IRQ_EN];
	assign low_irq_en   = st_reg.timer_control_reg[art_pkg::BIT_LOW_IRQ_EN];

	// A reserved capture source leaves the capture path idle
	assign capture_event = capture & lfo_fall;

	// ****************************************
	// Software write decode
	// ****************************************
	logic       wr_control;
	logic       wr_reload_low;
	logic       wr_reload_high;
	logic       wr_count_low;
	logic       wr_count_high;
	logic       wr_clock_ctrl;
	logic       wr_irq_enable;

	// Strobes are only taken while the block is enabled; offset 7 matches none
	assign wr_control     = ce_i & wr_i & (addr_i == art_pkg::OFF_CONTROL);
	assign wr_reload_low  = ce_i & wr_i & (addr_i == art_pkg::OFF_RELOAD_LOW);
	assign wr_reload_high = ce_i & wr_i & (addr_i == art_pkg::OFF_RELOAD_HIGH);
	assign wr_count_low   = ce_i & wr_i & (addr_i == art_pkg::OFF_COUNT_LOW);
	assign wr_count_high  = ce_i & wr_i & (addr_i == art_pkg::OFF_COUNT_HIGH);
	assign wr_clock_ctrl  = ce_i & wr_i & (addr_i == art_pkg::OFF_CLOCK_CTRL);
	assign wr_irq_enable  = ce_i & wr_i & (addr_i == art_pkg::OFF_IRQ_ENABLE);

	// ****************************************
	// Tick selection
	// ****************************************
	logic       prescaled_tick;
	logic       tick_low;
	logic       tick_high;

	// Both halves share one prescaler, so prescaled halves tick in step
	always_comb begin
		if (ext_sel) begin
			prescaled_tick = ext8_tick;
		end else begin
			prescaled_tick = sys12_tick;
		end
	end

	// A high clock enable is itself the system clock tick
	always_comb begin
		if (low_sys_sel) begin
			tick_low = ce_i;
		end else begin
			tick_low = prescaled_tick;
		end
	end

	always_comb begin
		if (high_sys_sel) begin
			tick_high = ce_i;
		end else begin
			tick_high = prescaled_tick;
		end
	end

	// ****************************************
	// Advance and wrap
	// ****************************************
	logic       low_full;
	logic       high_full;
	logic       adv_low;
	logic       adv_high;
	logic       wrap_low;
	logic       wrap_high;
	logic       wrap16;
	logic       reload_low_now;
	logic       reload_high_now;

	// Full means the next advance of that byte wraps it
	assign low_full  = (st_reg.count_low_byte == 8'hff);
	assign high_full = (st_reg.count_high_byte == 8'hff);

	// A software write to a count byte wins over that byte's advance
	// In 16-bit mode the low half's clock select drives the whole counter
	assign adv_low = tick_low & (split | run) & ~wr_count_low;

	always_comb begin
		if (split) begin
			adv_high = tick_high & run & ~wr_count_high;
		end else begin
			adv_high = adv_low & low_full & ~wr_count_high;
		end
	end

	assign wrap_low  = adv_low & low_full;
	assign wrap_high = adv_high & high_full;
	assign wrap16    = ~split & wrap_high;

	// Capture mode keeps the captured values, so counters wrap to zero there
	assign reload_low_now  = ~capture & (split ? wrap_low : wrap16);
	assign reload_high_now = ~capture & wrap_high;

	// ****************************************
	// Interrupt sources
	// ****************************************
	logic       irq_from_high;
	logic       irq_from_low;
	logic       irq_from_capture;

	// irq_o pulses once per cycle with any enabled event, so events in one cycle share a pulse, and holds while the clock enable is low
	assign irq_from_high    = timer_irq_en & wrap_high;
	assign irq_from_low     = timer_irq_en & low_irq_en & wrap_low;
	assign irq_from_capture = timer_irq_en & capture_event;

	// ****************************************
	// Register read
	// ****************************************
	// Unmapped offsets read as zero

	always_comb begin
		unique case (addr_i)
			art_pkg::OFF_CONTROL:     rd_val = st_reg.timer_control_reg;
			art_pkg::OFF_RELOAD_LOW:  rd_val = st_reg.reload_low_byte;
			art_pkg::OFF_RELOAD_HIGH: rd_val = st_reg.reload_high_byte;
			art_pkg::OFF_COUNT_LOW:   rd_val = st_reg.count_low_byte;
			art_pkg::OFF_COUNT_HIGH:  rd_val = st_reg.count_high_byte;
			art_pkg::OFF_CLOCK_CTRL:  rd_val = st_reg.clock_control_reg;
			art_pkg::OFF_IRQ_ENABLE:  rd_val = st_reg.interrupt_enable_reg;
			default:                  rd_val = 8'h00;
		endcase
	end

	// ****************************************
	// Next state
	// ****************************************
	always_comb begin
		st_next = st_reg;
		if (ce_i) begin
			st_next.irq = 1'b0;
			// Software writes first; hardware events below override them
			if (wr_control) begin
				st_next.timer_control_reg = wdata_i;
			end
			if (wr_reload_low) begin
				st_next.reload_low_byte = wdata_i;
			end
			if (wr_reload_high) begin
				st_next.reload_high_byte = wdata_i;
			end
			if (wr_count_low) begin
				st_next.count_low_byte = wdata_i;
			end
			if (wr_count_high) begin
				st_next.count_high_byte = wdata_i;
			end
			if (wr_clock_ctrl) begin
				st_next.clock_control_reg = wdata_i;
			end
			if (wr_irq_enable) begin
				st_next.interrupt_enable_reg = wdata_i;
			end
			// Read data stands for one cycle only, zero otherwise
			if (rd_i) begin
				st_next.rdata = rd_val;
			end else begin
				st_next.rdata = 8'h00;
			end

			// Low half
			if (adv_low) begin
				if (reload_low_now) begin
					st_next.count_low_byte = st_reg.reload_low_byte;
				end else begin
					st_next.count_low_byte = st_reg.count_low_byte + 8'h01;
				end
			end
			// High half
			if (adv_high) begin
				if (reload_high_now) begin
					st_next.count_high_byte = st_reg.reload_high_byte;
				end else begin
					st_next.count_high_byte = st_reg.count_high_byte + 8'h01;
				end
			end

			// Hardware sets the flags only here, though a control write can also set them; set wins over a clearing write
			if (wrap_high) begin
				st_next.timer_control_reg[art_pkg::BIT_HIGH_FLAG] = 1'b1;
			end
			// The low flag follows every low byte wrap, whatever the mode
			if (wrap_low) begin
				st_next.timer_control_reg[art_pkg::BIT_LOW_FLAG] = 1'b1;
			end

			// Capture copies the count taken before this cycle's increment
			if (capture_event) begin
				st_next.reload_low_byte  = st_reg.count_low_byte;
				st_next.reload_high_byte = st_reg.count_high_byte;
			end

			if (irq_from_high) begin
				st_next.irq = 1'b1;
			end
			if (irq_from_low) begin
				st_next.irq = 1'b1;
			end
			if (irq_from_capture) begin
				st_next.irq = 1'b1;
			end
		end
	end

	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	// ****************************************
	// Outputs
	// ****************************************
	assign rdata_o = st_reg.rdata;
	assign irq_o   = st_reg.irq;
endmodule

// ### common/art_pkg.sv
/*
 Constants for the auto-reload timer with oscillator capture: register offsets,
 control field positions, reset values and prescaler counts.
 Assumes a 100 MHz system clock and a plain strobe register port.
*/
package art_pkg;
	// ****************************************
	// Register offsets
	// ****************************************
	localparam logic [2:0] OFF_CONTROL     = 3'h0;
	localparam logic [2:0] OFF_RELOAD_LOW  = 3'h1;
	localparam logic [2:0] OFF_RELOAD_HIGH = 3'h2;
	localparam logic [2:0] OFF_COUNT_LOW   = 3'h3;
	localparam logic [2:0] OFF_COUNT_HIGH  = 3'h4;
	localparam logic [2:0] OFF_CLOCK_CTRL  = 3'h5;
	localparam logic [2:0] OFF_IRQ_ENABLE  = 3'h6;

	// ****************************************
	// Control register fields
	// ****************************************
	localparam int BIT_HIGH_FLAG   = 7;
	localparam int BIT_LOW_FLAG    = 6;
	localparam int BIT_LOW_IRQ_EN  = 5;
	localparam int BIT_CAPTURE_EN  = 4;
	localparam int BIT_SPLIT       = 3;
	localparam int BIT_RUN         = 2;
	localparam int BIT_CAPTURE_SRC = 1;
	localparam int BIT_EXT_CLK     = 0;

	// Clock control and interrupt enable fields
	localparam int BIT_HIGH_CLK_SEL = 1;
	localparam int BIT_LOW_CLK_SEL  = 0;
	localparam int BIT_TIMER_IRQ_EN = 0;

	localparam logic [7:0] RESET_BYTE = 8'h00;

	// ****************************************
	// Prescaler counts
	// ****************************************
	localparam logic [3:0] SYS_DIVIDE = 4'hc;
	localparam logic [1:0] EXT_DIVIDE = 2'h3;
endpackage

// ### verilog/art_sync.sv
/*
 Two-stage synchroniser with falling edge detection.
 Assumes the input is asynchronous to clk_i.
*/
`timescale 1ns/1ns
module art_sync (
	input  wire logic clk_i,    // System clock
	input  wire logic rst_n_i,  // Synchronised reset
	input  wire logic ce_i,     // Clock enable
	input  wire logic async_i,  // Asynchronous level
	output logic      level_o,  // Synchronised level
	output logic      fall_o    // One-cycle falling edge strobe
);
	typedef struct packed {
		logic s1;
		logic s2;
		logic s3;
	} art_sync_type;

	art_sync_type st_reg;
	art_sync_type st_next;

	always_comb begin
		st_next = st_reg;
		if (ce_i) begin
			st_next.s1 = async_i;
			st_next.s2 = st_reg.s1;
			st_next.s3 = st_reg.s2;
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	// Only the second and third stages feed logic
	assign level_o = st_reg.s2;
	assign fall_o  = ce_i & st_reg.s3 & ~st_reg.s2;
endmodule

// ### verilog/art_prescaler.sv
/*
 Tick generator: system clock divided by 12, or external oscillator divided by 8.
 Assumes the external oscillator is asynchronous; it is synchronised here.
*/
`timescale 1ns/1ns
module art_prescaler (
	input  wire logic clk_i,      // System clock
	input  wire logic rst_n_i,    // Synchronised reset
	input  wire logic ce_i,       // Clock enable
	input  wire logic ext_osc_i,  // External oscillator
	output logic      sys12_o,    // Tick every 12 system clocks
	output logic      ext8_o      // Tick every 8 external clocks
);
	typedef struct packed {
		logic [3:0] sys_cnt;
		logic [1:0] ext_cnt;
		logic       ext_half;
	} art_pre_type;

	art_pre_type st_reg;
	art_pre_type st_next;
	logic        ext_rise;
	logic        ext_level;
	logic        ext_fall;

	art_sync u_ext_sync (
		.clk_i   (clk_i),
		.rst_n_i (rst_n_i),
		.ce_i    (ce_i),
		.async_i (~ext_osc_i),
		.level_o (ext_level),
		.fall_o  (ext_fall)
	);

	// Falling edge of inverted input is a rising edge of the oscillator
	assign ext_rise = ext_fall;

	always_comb begin
		st_next = st_reg;
		if (ce_i) begin
			if (st_reg.sys_cnt == art_pkg::SYS_DIVIDE - 4'h1) begin
				st_next.sys_cnt = 4'h0;
			end else begin
				st_next.sys_cnt = st_reg.sys_cnt + 4'h1;
			end
			if (ext_rise) begin
				st_next.ext_cnt = st_reg.ext_cnt + 2'h1;
				if (st_reg.ext_cnt == art_pkg::EXT_DIVIDE) begin
					st_next.ext_half = ~st_reg.ext_half;
				end
			end
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	// Four rises per half period gives one tick per eight oscillator periods
	assign sys12_o = ce_i & (st_reg.sys_cnt == art_pkg::SYS_DIVIDE - 4'h1);
	assign ext8_o  = ext_rise & (st_reg.ext_cnt == art_pkg::EXT_DIVIDE) & st_reg.ext_half;
endmodule

// ### dv/art_timer_props.sv
/*
 Port checker for art_timer, with shadows of software writes.
 Assumes ce_i high and no write beside a read.
*/
`timescale 1ns/1ns
module art_timer_props (
	input wire logic       clk_i,     // Clock
	input wire logic       rst_n_i,   // Reset
	input wire logic       ce_i,      // Enable
	input wire logic [2:0] addr_i,    // Address
	input wire logic [7:0] wdata_i,   // Write data
	input wire logic       wr_i,      // Write
	input wire logic       rd_i,      // Read
	input wire logic       ext_osc_i, // Ext osc
	input wire logic       lfo_i,     // Slow osc
	input wire logic [7:0] rdata_o,   // Read data
	input wire logic       irq_o      // Interrupt
);
	// ****************
	// Shadows
	// ****************
	logic [7:0] ctl_q;
	logic       ie_q;
	logic       rdc_q;
	logic [1:0] seen_q;
	wire  logic act = |(ctl_q & 8'h1c);

	// Flags once seen set must stay set until software writes control
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			ctl_q <= 8'h00;
			ie_q <= 1'b0;
			rdc_q <= 1'b0;
			seen_q <= 2'h0;
		end else if (ce_i) begin
			rdc_q <= rd_i && addr_i == art_pkg::OFF_CONTROL;
			if (wr_i && addr_i == art_pkg::OFF_CONTROL) begin
				ctl_q <= wdata_i;
				seen_q <= 2'h0;
			end else if (rdc_q) begin
				seen_q <= seen_q | rdata_o[7:6];
			end
			if (wr_i && addr_i == art_pkg::OFF_IRQ_ENABLE) begin
				ie_q <= wdata_i[art_pkg::BIT_TIMER_IRQ_EN];
			end
		end
	end

	// ****************
	// Assertions
	// ****************
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);

	AST_RESET_QUIET: assert property (disable iff (1'b0) !rst_n_i |-> !irq_o && !rdata_o)
		else $error("outputs active in reset");
	AST_RDATA_IDLE: assert property (!$past(rd_i && ce_i) |-> rdata_o == 8'h00)
		else $error("read data without read");
	AST_UNMAPPED: assert property ($past(rd_i && addr_i == 3'h7) |-> rdata_o == 8'h00)
		else $error("unmapped read not zero");
	AST_RELOAD_RB: assert property (wr_i && addr_i == art_pkg::OFF_RELOAD_LOW ##2
		rd_i && addr_i == art_pkg::OFF_RELOAD_LOW |=> rdata_o == $past(wdata_i, 3))
		else $error("reload readback wrong");
	AST_CTL_RB: assert property (rdc_q |-> rdata_o[5:0] == $past(ctl_q[5:0]))
		else $error("control readback wrong");
	AST_FLAG_STICKY: assert property (rdc_q |-> (rdata_o[7:6] & seen_q) == seen_q)
		else $error("flag cleared by hardware");
	AST_IRQ_EN: assert property (irq_o |-> ie_q || $past(ie_q))
		else $error("interrupt while disabled");
	AST_STOPPED: assert property (irq_o |-> act || $past(act))
		else $error("interrupt from stopped timer");
	AST_CAPTURE: assert property ($fell(lfo_i) && ctl_q[4] && ctl_q[1] && ie_q
		|-> ##[1:6] irq_o)
		else $error("no capture interrupt");

	COV_IRQ: cover property (irq_o);
	COV_HIGH: cover property (rdc_q && rdata_o[7]);
	COV_LOW: cover property (rdc_q && rdata_o[6]);
endmodule

bind art_timer art_timer_props chk (
	.clk_i(clk_i),
	.rst_n_i(rst_n_i),
	.ce_i(ce_i),
	.addr_i(addr_i),
	.wdata_i(wdata_i),
	.wr_i(wr_i),
	.rd_i(rd_i),
	.ext_osc_i(ext_osc_i),
	.lfo_i(lfo_i),
	.rdata_o(rdata_o),
	.irq_o(irq_o)
);

// ### dv/test_art_timer.sv
/*
 Self-checking bench for art_timer.
 Assumes the checker is bound in by its own file.
*/
`timescale 1ns/1ns
`define CHK(n, e, a) begin samples_checked++; if ((a) !== (e)) begin miscompares++; \
	$display("MISMATCH %s exp %h got %h", n, e, a); end end
module test_art_timer;
	logic       clk_i;
	logic       rst_n_i;
	logic       ce_i;
	logic       wr_i;
	logic       rd_i;
	logic       ext_osc_i;
	logic       lfo_i;
	logic       irq_o;
	logic [2:0] addr_i;
	logic [7:0] wdata_i;
	logic [7:0] rdata_o;
	logic [7:0] v;
	int         miscompares;
	int         samples_checked;

	art_timer uut (.clk_i(clk_i), .rst_n_i(rst_n_i), .ce_i(ce_i), .addr_i(addr_i),
		.wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .ext_osc_i(ext_osc_i),
		.lfo_i(lfo_i), .rdata_o(rdata_o), .irq_o(irq_o));

	initial begin
		clk_i = 1'b0;
		forever #5 clk_i = ~clk_i;
	end
	// External oscillator at one sixth of the system clock
	initial begin
		ext_osc_i = 1'b0;
		forever begin
			repeat (3) @(posedge clk_i);
			ext_osc_i <= ~ext_osc_i;
		end
	end

	// ****************
	// Bus tasks
	// ****************
	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		@(posedge clk_i);
		addr_i <= a;
		wdata_i <= d;
		wr_i <= 1'b1;
		@(posedge clk_i);
		wr_i <= 1'b0;
	endtask
	task automatic rd(input logic [2:0] a);
		@(posedge clk_i);
		addr_i <= a;
		rd_i <= 1'b1;
		@(posedge clk_i);
		rd_i <= 1'b0;
		#1 v = rdata_o;
	endtask
	task automatic stop_test();
		$display("checked %0d mismatches %0d", samples_checked, miscompares);
		if (miscompares == 0 && samples_checked > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	task automatic wait_irq(input int n);
		for (int i = 0; i < n; i++) begin
			@(posedge clk_i);
			#1 if (irq_o === 1'b1) return;
		end
		miscompares++;
		stop_test();
	endtask

	// ****************
	// Scenarios
	// ****************
	task automatic t_reset();
		for (int a = 0; a < 8; a++) begin
			rd(3'(a));
			`CHK("reg", 8'h00, v)
		end
	endtask
	task automatic t_wide();
		wr(art_pkg::OFF_CLOCK_CTRL, 8'h01);
		wr(art_pkg::OFF_IRQ_ENABLE, 8'h01);
		wr(art_pkg::OFF_RELOAD_LOW, 8'h34);
		rd(art_pkg::OFF_RELOAD_LOW);
		`CHK("rl_l", 8'h34, v)
		wr(art_pkg::OFF_RELOAD_HIGH, 8'h12);
		wr(art_pkg::OFF_COUNT_LOW, 8'hfe);
		wr(art_pkg::OFF_COUNT_HIGH, 8'hff);
		wr(art_pkg::OFF_CONTROL, 8'h04);
		wait_irq(8);
		rd(art_pkg::OFF_CONTROL);
		`CHK("ctl", 8'hc4, v)
		rd(art_pkg::OFF_COUNT_HIGH);
		`CHK("cnt_h", 8'h12, v)
		rd(art_pkg::OFF_CONTROL);
		`CHK("ctl", 8'hc4, v)
		wr(art_pkg::OFF_CONTROL, 8'h24);
		wait_irq(300);
		rd(art_pkg::OFF_CONTROL);
		`CHK("ctl", 8'h64, v)
	endtask
	task automatic t_split();
		wr(art_pkg::OFF_CONTROL, 8'h08);
		wr(art_pkg::OFF_RELOAD_LOW, 8'ha0);
		wr(art_pkg::OFF_RELOAD_HIGH, 8'h50);
		wr(art_pkg::OFF_COUNT_HIGH, 8'hfe);
		wr(art_pkg::OFF_COUNT_LOW, 8'hfe);
		repeat (4) @(posedge clk_i);
		rd(art_pkg::OFF_CONTROL);
		`CHK("ctl", 8'h48, v)
		rd(art_pkg::OFF_COUNT_LOW);
		`CHK("cnt_l", 4'ha, v[7:4])
		rd(art_pkg::OFF_COUNT_HIGH);
		`CHK("cnt_h", 8'hfe, v)
		wr(art_pkg::OFF_CLOCK_CTRL, 8'h03);
		wr(art_pkg::OFF_CONTROL, 8'h0c);
		wait_irq(8);
		rd(art_pkg::OFF_COUNT_HIGH);
		`CHK("cnt_h", 4'h5, v[7:4])
		wr(art_pkg::OFF_CONTROL, 8'h28);
		wait_irq(120);
	endtask
	task automatic t_clk();
		int e;
		for (int x = 0; x < 2; x++) begin
			e = x ? 10 : 40;
			wr(art_pkg::OFF_CLOCK_CTRL, 8'h00);
			wr(art_pkg::OFF_COUNT_LOW, 8'h00);
			wr(art_pkg::OFF_CONTROL, 8'(4 + x));
			repeat (480) @(posedge clk_i);
			wr(art_pkg::OFF_CONTROL, 8'h00);
			rd(art_pkg::OFF_COUNT_LOW);
			`CHK("ticks", 1'b1, v >= e - 1 && v <= e + 1)
		end
	endtask
	// A low clock enable must freeze the counter
	task automatic t_ce();
		wr(art_pkg::OFF_CLOCK_CTRL, 8'h01);
		wr(art_pkg::OFF_COUNT_LOW, 8'h10);
		wr(art_pkg::OFF_CONTROL, 8'h04);
		@(posedge clk_i);
		ce_i <= 1'b0;
		repeat (20) @(posedge clk_i);
		ce_i <= 1'b1;
		wr(art_pkg::OFF_CONTROL, 8'h00);
		rd(art_pkg::OFF_COUNT_LOW);
		`CHK("cnt_ce", 8'h13, v)
	endtask
	task automatic t_cap();
		wr(art_pkg::OFF_CLOCK_CTRL, 8'h01);
		wr(art_pkg::OFF_COUNT_HIGH, 8'h12);
		wr(art_pkg::OFF_COUNT_LOW, 8'h00);
		wr(art_pkg::OFF_CONTROL, 8'h16);
		lfo_i <= 1'b0;
		wait_irq(8);
		rd(art_pkg::OFF_RELOAD_HIGH);
		`CHK("rl_h", 8'h12, v)
		wr(art_pkg::OFF_COUNT_HIGH, 8'hff);
		wr(art_pkg::OFF_COUNT_LOW, 8'hf0);
		repeat (30) @(posedge clk_i);
		rd(art_pkg::OFF_COUNT_HIGH);
		`CHK("cnt_h", 8'h00, v)
		wr(art_pkg::OFF_CONTROL, 8'h14);
		lfo_i <= 1'b1;
		repeat (5) @(posedge clk_i);
		lfo_i <= 1'b0;
		repeat (10) @(posedge clk_i);
		rd(art_pkg::OFF_RELOAD_HIGH);
		`CHK("rl_h", 8'h12, v)
	endtask

	initial begin
		rst_n_i = 1'b0;
		ce_i = 1'b1;
		wr_i = 1'b0;
		rd_i = 1'b0;
		addr_i = 3'h0;
		wdata_i = 8'h00;
		lfo_i = 1'b1;
		miscompares = 0;
		samples_checked = 0;
		repeat (20) @(posedge clk_i);
		rst_n_i <= 1'b1;
		repeat (3) @(posedge clk_i);
		t_reset();
		t_wide();
		t_split();
		t_clk();
		t_ce();
		t_cap();
		stop_test();
	end
endmodule
